// ### rtl/lmra_core.sv
/*
 Device-side mode register access: 64 mode registers, read bursts on DQ,
 writes with read-only protection, boost current mode settling.
 Assumes the controller keeps its command spacing; commands arrive decoded
 as one-cycle strobes synchronous to core_clk.
*/
// Function
// (RULE1) Clock stop only with refreshes running
// (RULE2) Commands finish plus four cycles before stop
// (RULE3) Related timings expire before clock stop
// (RULE4) Auto precharge needs four extra cycles
// (RULE5) Refresh and ZQ need four cycles
// (RULE6) Ready two periods plus tXP after restart
// (RULE7) Six-bit address selects one of 64
// (RULE8) Value on DQ7:0 first four UI
// (RULE9) Read burst sixteen beats, strobe toggling
// (RULE10) No interruption, only deselect during tMRR
// (RULE11) Inversion per MR3 bit 6, normal preamble
// (RULE12) Read and write spacing before register read
// (RULE13) Turnaround counts after last write strobe
// (RULE14) Power-down exit waits tXP plus tRCD
// (RULE15) Writes to read-only registers ignored
// (RULE16) Access from idle or active banks
// (RULE17) Register write spacing tMRW and tMRD
// (RULE18) Register read to write spacing
// (RULE19) Read to register write spacing
// (RULE20) Auto precharge read adds nRTP minus eight
// (RULE21) Auto precharge write adds nWR
// (RULE22) MR13 bit 3 set enables boost
// (RULE23) MR13 bit 3 clear disables boost
// (RULE24) Clock stop holds select and clock levels
// (RULE25) Boost settles within 200/100 ns
// (RULE26) Bit i on DQ line i
`timescale 1ns/1ps
`include "lmra_defs.svh"
module lmra_core (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic mrr_req,
   input wire logic mrw_req,
   input wire lmra_pkg::lmra_addr_t mr_addr,
   input wire lmra_pkg::lmra_data_t mr_wdata,
   input wire logic [5:0] read_latency,
   input wire logic [63:0] mr_read_only,
   input wire lmra_pkg::lmra_data_t mr_status_in,
   input wire logic [63:0] mr_status_sel,
   output logic [7:0] dq_out,
   output logic [7:0] dq_hi_out,
   output logic [1:0] dmi_out,
   output logic dq_oe,
   output logic dqs_t_out,
   output logic dqs_c_out,
   output logic dqs_oe,
   output logic mrr_busy,
   output logic vref_boost_current_mode,
   output logic vref_boost_settling,
   output lmra_pkg::lmra_data_t mr13_value
);
   import lmra_pkg::*;

   lmra_data_t mr_r [`LMRA_NUM_MR];
   lmra_rd_e rd_state_r;
   logic [5:0] lat_cnt_r;
   logic [4:0] beat_r;
   lmra_data_t rdata_r;
   logic dbi_r;
   logic boost_r;
   logic [7:0] dq_r;
   logic dmi_r;
   logic dqs_r;
   logic [5:0] lat_load;
   logic load_beat;
   logic invert;
   lmra_data_t dq_nxt;
   logic dmi_nxt;
   lmra_settle_if st ();

   lmra_settle_timer u_settle (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .st(st)
   );

   // Writes never look at bank state, and commands are taken on any running edge,
   // so there is no wake-up delay of our own after a clock restart
   always_ff @(posedge core_clk) begin // RULE6 RULE16
      if (sys_rst) begin
         for (int i = 0; i < `LMRA_NUM_MR; i++) begin
            mr_r[i] <= 8'h00;
         end
      end else if (mrw_req && !mr_read_only[mr_addr]) begin // RULE15
         mr_r[mr_addr] <= mr_wdata;
      end
   end

   // Boost mode follows MR13 bit 3, and a change of that bit arms the settling window
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         boost_r <= 1'b0;
      end else if (mrw_req && !mr_read_only[mr_addr] && mr_addr == 6'(`LMRA_MR_BOOST)) begin
         boost_r <= mr_wdata[`LMRA_BOOST_BIT]; // RULE22 RULE23
      end
   end

   assign st.start = mrw_req && !mr_read_only[mr_addr] && mr_addr == 6'(`LMRA_MR_BOOST)
      && (mr_wdata[`LMRA_BOOST_BIT] != boost_r);
   // Settling counts at the floor of the limit, so the device is never later than it (RULE25)
   assign st.cycles = mr_wdata[`LMRA_BOOST_BIT] ? 4'(`LMRA_BOOST_EN_CYC) :
      4'(`LMRA_BOOST_DIS_CYC); // RULE25

   assign lat_load = (read_latency == 6'h00) ? 6'h01 : read_latency;

   // Register read: wait RL cycles, then a fixed sixteen-beat burst
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         rd_state_r <= LMRA_IDLE;
      end else begin
         unique case (rd_state_r)
            LMRA_IDLE: begin
               // Requests outside idle are ignored, so a burst never aborts
               if (mrr_req) begin // RULE10
                  rd_state_r <= LMRA_WAIT;
               end
            end
            LMRA_WAIT: begin
               if (lat_cnt_r == 6'h01) begin
                  rd_state_r <= LMRA_BURST;
               end
            end
            LMRA_BURST: begin
               if (beat_r == 5'(`LMRA_MRR_BEATS - 1)) begin // RULE9
                  rd_state_r <= LMRA_IDLE;
               end
            end
            default: begin
               // The unused code falls back to idle rather than locking up
               rd_state_r <= LMRA_IDLE;
            end
         endcase
      end
   end

   // Latency counter, loaded with the accepted request
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         lat_cnt_r <= 6'h00;
      end else if (rd_state_r == LMRA_IDLE && mrr_req) begin
         lat_cnt_r <= lat_load;
      end else if (rd_state_r == LMRA_WAIT && lat_cnt_r != 6'h01) begin
         lat_cnt_r <= lat_cnt_r - 6'h01;
      end
   end

   // Beat counter within the burst
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         beat_r <= 5'h00;
      end else if (rd_state_r == LMRA_WAIT) begin
         beat_r <= 5'h00;
      end else if (rd_state_r == LMRA_BURST) begin
         beat_r <= beat_r + 5'h01;
      end
   end

   // Value and inversion mode are captured with the command, so a later write
   // cannot change a burst already in flight
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         rdata_r <= 8'h00;
         dbi_r <= 1'b0;
      end else if (rd_state_r == LMRA_IDLE && mrr_req) begin
         // Status registers are sampled from live state when selected
         rdata_r <= mr_status_sel[mr_addr] ? mr_status_in : mr_r[mr_addr]; // RULE7
         dbi_r <= mr_r[`LMRA_MR_DBI][`LMRA_DBI_BIT]; // RULE11
      end
   end

   // Data leaves through a register, so each beat is loaded on the edge before it
   // shows; the first four beats of the window carry the value
   assign load_beat = (rd_state_r == LMRA_WAIT && lat_cnt_r == 6'h01)
      || (rd_state_r == LMRA_BURST && beat_r < 5'(`LMRA_MRR_VALID_UI - 1)); // RULE8
   assign invert = dbi_r && ($countones(rdata_r) > `LMRA_DBI_MAX_ONES); // RULE11

   always_comb begin
      dq_nxt = 8'h00;
      dmi_nxt = 1'b0;
      if (load_beat) begin
         dq_nxt = invert ? ~rdata_r : rdata_r; // RULE26
         dmi_nxt = invert;
      end
   end

   // Two beats per cycle are folded to one beat per core cycle here
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         dq_r <= 8'h00;
      end else begin
         dq_r <= dq_nxt;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         dmi_r <= 1'b0;
      end else begin
         dmi_r <= dmi_nxt;
      end
   end

   // Strobe runs only inside the burst and parks low between bursts
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         dqs_r <= 1'b0;
      end else if (rd_state_r == LMRA_BURST) begin
         dqs_r <= ~dqs_r; // RULE9
      end else begin
         dqs_r <= 1'b0;
      end
   end

   assign dq_out = dq_r;
   assign dq_hi_out = 8'h00;
   assign dmi_out = {1'b0, dmi_r};
   assign dq_oe = (rd_state_r == LMRA_BURST); // RULE9
   assign dqs_t_out = dqs_r;
   assign dqs_c_out = ~dqs_r;
   assign dqs_oe = dq_oe;
   assign mrr_busy = (rd_state_r != LMRA_IDLE);
   assign vref_boost_current_mode = boost_r;
   assign vref_boost_settling = st.busy;
   assign mr13_value = mr_r[`LMRA_MR_BOOST];
endmodule

// ### rtl/lmra_defs.svh
/*
 Constants for the mode register access block: register file size, field positions,
 burst and timing figures. Assumes core_clk at 25 MHz.
*/
`ifndef LMRA_DEFS_SVH
`define LMRA_DEFS_SVH

`define LMRA_CLK_MHZ 25
`define LMRA_NUM_MR 64
`define LMRA_MR_AW 6
`define LMRA_MR_DBI 3
`define LMRA_DBI_BIT 6
`define LMRA_DBI_MAX_ONES 4
`define LMRA_MR_BOOST 13
`define LMRA_BOOST_BIT 3
`define LMRA_MRR_BEATS 16
`define LMRA_MRR_VALID_UI 4
`define LMRA_RL_DEF 6'h0E
`define LMRA_T_BOOST_EN_NS 200
`define LMRA_T_BOOST_DIS_NS 100
// Longest times round down, never below one cycle
`define LMRA_CYC_FLOOR(ns) ((((ns) * `LMRA_CLK_MHZ) / 1000) < 1 ? 1 : \
   (((ns) * `LMRA_CLK_MHZ) / 1000))
`define LMRA_BOOST_EN_CYC `LMRA_CYC_FLOOR(`LMRA_T_BOOST_EN_NS)
`define LMRA_BOOST_DIS_CYC `LMRA_CYC_FLOOR(`LMRA_T_BOOST_DIS_NS)

`endif

// ### rtl/lmra_pkg.sv
/*
 Types for the mode register access block.
 Assumes lmra_defs.svh is visible in the same compile unit.
*/
package lmra_pkg;
   typedef logic [5:0] lmra_addr_t;
   typedef logic [7:0] lmra_data_t;
   typedef enum logic [1:0] {LMRA_IDLE, LMRA_WAIT, LMRA_BURST} lmra_rd_e;
endpackage

// ### rtl/lmra_settle_if.sv
/*
 Interface between the access core and its settling timer.
 Assumes a single clock domain shared by both ends.
*/
`timescale 1ns/1ps
interface lmra_settle_if;
   logic start;
   logic [3:0] cycles;
   logic busy;
   modport core (output start, output cycles, input busy);
   modport timer (input start, input cycles, output busy);
endinterface

// ### rtl/lmra_settle_timer.sv
/*
 Down counter that reports busy while a boost current change settles.
 Assumes start is a one-cycle pulse with the cycle count alongside.
*/
`timescale 1ns/1ps
module lmra_settle_timer (
   input wire logic core_clk,
   input wire logic sys_rst,
   lmra_settle_if.timer st
);
   logic [3:0] cnt_r;

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         cnt_r <= 4'h0;
      end else if (st.start) begin
         cnt_r <= st.cycles;
      end else if (cnt_r != 4'h0) begin
         cnt_r <= cnt_r - 4'h1;
      end
   end

   assign st.busy = (cnt_r != 4'h0);
endmodule

// ### verification/lmra_core_assertions.sv
/* Checker for the mode register access block.
   Assumes one clock domain and that it is bound to lmra_core. */
`timescale 1ns/1ps
module lmra_chk (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic mrw_req,
   input wire lmra_pkg::lmra_addr_t mr_addr,
   input wire lmra_pkg::lmra_data_t mr_wdata,
   input wire logic [63:0] mr_read_only,
   input wire logic [7:0] dq_hi_out,
   input wire logic dq_oe,
   input wire logic dqs_t_out,
   input wire logic dqs_c_out,
   input wire logic dqs_oe,
   input wire logic vref_boost_current_mode,
   input wire logic vref_boost_settling,
   input wire lmra_pkg::lmra_data_t mr13_value
);
   import lmra_pkg::*;
   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   wire logic w13 = mrw_req && mr_addr == 6'h0D;
   sequence half; dq_oe [*8]; endsequence
   sequence b_on; w13 && !mr_read_only[13] && mr_wdata[3] && !vref_boost_current_mode; endsequence
   sequence b_off; w13 && !mr_read_only[13] && !mr_wdata[3] && vref_boost_current_mode; endsequence
   sequence mr13_took;
      mr13_value == $past(mr_wdata) && vref_boost_current_mode == $past(mr_wdata[3]);
   endsequence
   sequence on_win; vref_boost_settling [*5] ##1 !vref_boost_settling; endsequence
   sequence off_win; vref_boost_settling [*2] ##1 !vref_boost_settling; endsequence
   a_hi_zero: assert property (dq_hi_out == 8'h00) else $error("upper byte");
   a_burst_len: assert property ($rose(dq_oe) |-> half ##1 half ##1 !dq_oe) else $error("len");
   a_dqs_tog: assert property (dqs_oe && $past(dqs_oe) |-> $changed(dqs_t_out)) else $error("tog");
   a_dqs_pair: assert property (dqs_oe |-> dqs_c_out != dqs_t_out) else $error("pair");
   a_oe_same: assert property (dq_oe == dqs_oe) else $error("oe");
   a_mr13_set: assert property (w13 && !mr_read_only[13] |=> mr13_took)
      else $error("mr13");
   a_ro_keep: assert property (w13 && mr_read_only[13] |=> $stable(mr13_value)) else $error("ro");
   a_on_settle: assert property (b_on |=> on_win) else $error("on time");
   a_off_settle: assert property (b_off |=> off_win) else $error("off time");
endmodule
bind lmra_core lmra_chk u_chk (.core_clk, .sys_rst, .mrw_req, .mr_addr, .mr_wdata, .mr_read_only,
   .dq_hi_out, .dq_oe, .dqs_t_out, .dqs_c_out, .dqs_oe, .vref_boost_current_mode,
   .vref_boost_settling, .mr13_value);

// ### verification/lmra_ctl_model.sv
/* Controller model: issues register writes with legal spacing, and register reads that may be repeated early.
   Assumes commands change on the falling edge of core_clk. */
`timescale 1ns/1ps
module lmra_ctl_model (
   input wire logic core_clk,
   input wire logic mrr_busy,
   output logic mrr_req,
   output logic mrw_req,
   output lmra_pkg::lmra_addr_t mr_addr,
   output lmra_pkg::lmra_data_t mr_wdata
);
   import lmra_pkg::*;
   // Only register commands are issued and the clock never stops, so the data,
   // power-down and clock-stop spacings are kept by construction
   initial begin
      {mrr_req, mrw_req, mr_addr, mr_wdata} = '0;
   end
   // Released buses show the inverse so a stale value never looks valid
   task automatic idle();
      {mrr_req, mrw_req} = '0;
      mr_addr = ~mr_addr;
      mr_wdata = ~mr_wdata;
   endtask
   task automatic mrw(input lmra_addr_t a, input lmra_data_t d);
      @(negedge core_clk) {mrw_req, mr_addr, mr_wdata} = {1'b1, a, d};
      @(negedge core_clk) idle();
      @(negedge core_clk);
   endtask
   // Repeating early is the only illegal command this model issues
   task automatic mrr(input lmra_addr_t a, input logic dup);
      for (int j = 0; j <= dup; j++) begin
         @(negedge core_clk) {mrr_req, mr_addr} = {1'b1, a};
         @(negedge core_clk) idle();
      end
      for (int k = 0; k < 100 && (k < 2 || mrr_busy); k++) @(negedge core_clk);
   endtask
endmodule

// ### verification/lmra_tb.sv
/* Self-checking bench for the mode register access block.
   Assumes the controller model and the bound checker. */
`timescale 1ns/1ps
module testbench;
   import lmra_pkg::*;
   logic core_clk = 0, sys_rst = 1, mrr_req, mrw_req, dq_oe, dqs_t_out, dqs_c_out, dqs_oe;
   logic mrr_busy, vref_boost_current_mode, vref_boost_settling, dbi = 0;
   logic [5:0] read_latency = 6'h0E;
   logic [63:0] mr_read_only = '0, mr_status_sel = '0;
   lmra_addr_t mr_addr;
   lmra_data_t mr_wdata, mr_status_in = '0, dq_out, dq_hi_out, mr13_value, exp_q[$];
   logic [1:0] dmi_out;
   logic inv_q[$];
   int num_errors = 0, n_checks = 0, beats = 0, cyc = 0;
   integer seed = 32'hba2a_17fc;
   always #20 core_clk = ~core_clk;
   lmra_core dut (.core_clk, .sys_rst, .mrr_req, .mrw_req, .mr_addr, .mr_wdata, .read_latency,
      .mr_read_only, .mr_status_in, .mr_status_sel, .dq_out, .dq_hi_out, .dmi_out, .dq_oe,
      .dqs_t_out, .dqs_c_out, .dqs_oe, .mrr_busy, .vref_boost_current_mode,
      .vref_boost_settling, .mr13_value);
   lmra_ctl_model ctl (.core_clk, .mrr_busy, .mrr_req, .mrw_req, .mr_addr, .mr_wdata);
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic conclude();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic rd(input lmra_addr_t a, input lmra_data_t v, input logic dup);
      logic inv;
      inv = dbi && ($countones(v) > 4);
      exp_q.push_back(inv ? ~v : v);
      inv_q.push_back(inv);
      ctl.mrr(a, dup);
      cmp({7'h00, mrr_busy}, 8'h00);
   endtask
   // The value must stand on each of the first four beats of the window
   always @(negedge core_clk) begin
      if (++cyc > 6000) begin
         num_errors++;
         conclude();
      end
      if (dq_oe === 1'b1) begin
         beats++;
         if (beats <= 4) begin
            cmp(dq_out, exp_q.size() ? exp_q[0] : 8'hxx);
            cmp({6'h00, dmi_out}, {7'h00, (inv_q.size() ? inv_q[0] : 1'bx)});
         end
         if (beats == 4 && exp_q.size() && inv_q.size()) begin
            void'(exp_q.pop_front());
            void'(inv_q.pop_front());
         end
      end else if (beats != 0) begin
         cmp(8'(beats), 8'h10);
         beats = 0;
      end
   end
   initial begin
      lmra_addr_t a;
      lmra_data_t d;
      repeat (20) @(negedge core_clk);
      sys_rst = 0;
      for (int i = 0; i < 5; i++) begin
         a = {1'b1, 5'($random(seed))};
         d = 8'($random(seed));
         read_latency = 6'(1 + 4 * i);
         ctl.mrw(a, d);
         rd(a, d, i == 2);
      end
      ctl.mrw(6'h03, 8'h40);
      dbi = 1;
      ctl.mrw(6'h21, 8'hF7);
      rd(6'h21, 8'hF7, 0);
      mr_status_sel[5] = 1;
      mr_status_in = 8'($random(seed));
      rd(6'h05, mr_status_in, 0);
      mr_read_only[13] = 1;
      ctl.mrw(6'h0D, 8'h08);
      cmp(mr13_value, 8'h00);
      cmp({7'h00, vref_boost_current_mode}, 8'h00);
      mr_read_only[13] = 0;
      ctl.mrw(6'h0D, 8'h08);
      cmp({7'h00, vref_boost_current_mode}, 8'h01);
      cmp({7'h00, vref_boost_settling}, 8'h01);
      repeat (6) @(negedge core_clk);
      cmp({7'h00, vref_boost_settling}, 8'h00);
      ctl.mrw(6'h0D, 8'h00);
      cmp({7'h00, vref_boost_current_mode}, 8'h00);
      cmp({7'h00, vref_boost_settling}, 8'h01);
      repeat (4) @(negedge core_clk);
      cmp({7'h00, vref_boost_settling}, 8'h00);
      conclude();
   end
endmodule
